// *** hdl/lmcd_top.sv ***
// mode, clock scheme and transmit driver monitor control
`timescale 1ns/10ps
module lmcd_top
    import lmcd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic single_freq_enable_i,
    input wire logic single_freq_enable_drv_i,
    input wire logic control_mode_select_i,
    input wire logic control_mode_select_drv_i,
    input wire logic e3_select_i,
    input wire logic e3_select_drv_i,
    input wire logic sts1_ds3_select_i,
    input wire logic sts1_ds3_select_drv_i,
    input wire logic rail_format_select_i,
    input wire logic rail_format_select_drv_i,
    input wire lmcd_pkg::lmcd_rate_t host_rate_i,
    input wire logic host_single_rail_i,
    input wire logic transmit_clock_i,
    input wire logic monitor_tip_input_i,
    input wire logic monitor_tip_drv_i,
    input wire logic monitor_ring_input_i,
    input wire logic monitor_ring_drv_i,
    output logic host_mode_o,
    output lmcd_pkg::lmcd_rate_t rate_o,
    output logic single_rail_o,
    output logic coder_enable_o,
    output logic ref_is_12m_o,
    output logic synthesized_clock_output_o,
    output logic driver_fail_flag_o
);
    import lmcd_pkg::*;

    logic sfm_pin;
    logic host_pin;
    logic e3_pin;
    logic sd_pin;
    logic sr_pin;
    logic monitor_tip_input_pin;
    logic monitor_ring_input_pin;
    lmcd_rate_t hw_rate;
    lmcd_rate_t rate_nxt;
    logic sr_nxt;
    logic host_mode_r;
    lmcd_rate_t rate_r;
    logic single_rail_r;
    logic sfm_r;
    logic transmit_clock_d_r;
    logic transmit_clock_rise;
    logic mon_prev_r;
    logic mon_any;
    logic mon_edge;
    logic [LMCD_DMO_CNT_W-1:0] idle_cnt_r;
    logic fail_r;

    // undriven pins resolve to the internal pull level
    function automatic logic pin_level(logic val, logic drv, logic pull);
        return drv ? val : pull;
    endfunction

    always_comb
    begin
        host_pin = pin_level(control_mode_select_i,
                             control_mode_select_drv_i, 1'b1);
        sfm_pin = pin_level(single_freq_enable_i,
                            single_freq_enable_drv_i, 1'b0);
        e3_pin = pin_level(e3_select_i, e3_select_drv_i, 1'b0);
        sd_pin = pin_level(sts1_ds3_select_i,
                           sts1_ds3_select_drv_i, 1'b0);
        sr_pin = pin_level(rail_format_select_i,
                           rail_format_select_drv_i, 1'b0);
        monitor_tip_input_pin = pin_level(monitor_tip_input_i,
                             monitor_tip_drv_i, 1'b0);
        monitor_ring_input_pin = pin_level(monitor_ring_input_i,
                              monitor_ring_drv_i, 1'b0);
    end

    always_comb
    begin
        if (e3_pin)
        begin
            hw_rate = LMCD_RATE_E3;
        end
        else if (sd_pin)
        begin
            hw_rate = LMCD_RATE_STS1;
        end
        else
        begin
            hw_rate = LMCD_RATE_DS3;
        end
        // host mode drops the discrete rate and rail pins
        rate_nxt = host_pin ? host_rate_i : hw_rate;
        sr_nxt = host_pin ? host_single_rail_i : sr_pin;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            host_mode_r <= 1'b1;
            rate_r <= LMCD_RATE_DS3;
            single_rail_r <= 1'b0;
            sfm_r <= 1'b0;
        end
        else if (ce_i)
        begin
            host_mode_r <= host_pin;
            rate_r <= rate_nxt;
            single_rail_r <= sr_nxt;
            sfm_r <= sfm_pin;
        end
    end

    assign host_mode_o = host_mode_r;
    assign rate_o = rate_r;
    assign single_rail_o = single_rail_r;
    // coder follows the rail format; in dual rail it is bypassed
    assign coder_enable_o = single_rail_r;
    // a 0 here means the reference must already be at line rate
    assign ref_is_12m_o = sfm_r;

    lmcd_clk_synth u_synth
    (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .run_i(sfm_r),
        .rate_i(rate_r),
        .synth_clk_o(synthesized_clock_output_o)
    );

    // transmit clock sampled as a plain synchronous input
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            transmit_clock_d_r <= 1'b0;
            mon_prev_r <= 1'b0;
        end
        else if (ce_i)
        begin
            transmit_clock_d_r <= transmit_clock_i;
            if (transmit_clock_i && !transmit_clock_d_r)
            begin
                mon_prev_r <= mon_any;
            end
        end
    end

    assign transmit_clock_rise = transmit_clock_i & ~transmit_clock_d_r;
    assign mon_any = monitor_tip_input_pin | monitor_ring_input_pin;
    // a rising pulse on either rail counts as a transition
    assign mon_edge = mon_any & ~mon_prev_r;

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            idle_cnt_r <= '0;
        end
        else if (ce_i && transmit_clock_rise)
        begin
            if (mon_edge)
            begin
                idle_cnt_r <= '0;
            end
            else if (idle_cnt_r != LMCD_DMO_TERM)
            begin
                idle_cnt_r <= idle_cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            fail_r <= LMCD_RST_FAIL;
        end
        else if (ce_i && transmit_clock_rise)
        begin
            if (mon_edge)
            begin
                fail_r <= 1'b0;
            end
            else if (idle_cnt_r == LMCD_DMO_TERM - 8'h01)
            begin
                fail_r <= 1'b1;
            end
        end
    end

    assign driver_fail_flag_o = fail_r;

    a_fail_needs_idle: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        $rose(fail_r) |-> idle_cnt_r == LMCD_DMO_TERM)
        else $error("fail flag rose without full idle count");

    a_fail_clears_pulse: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && transmit_clock_rise && mon_edge && fail_r) |=> !fail_r)
        else $error("fail flag not cleared by monitor pulse");

    a_cnt_clear_edge: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && transmit_clock_rise && mon_edge) |=> idle_cnt_r == '0)
        else $error("idle counter not cleared on transition");

    a_clk_low_nosfm: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (!sfm_r)[*2] |-> !synthesized_clock_output_o)
        else $error("clock out toggles outside single frequency");

    a_host_rate_pass: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && host_pin) |=> rate_r == $past(host_rate_i))
        else $error("host mode rate not taken from host");

    a_e3_wins: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && !host_pin && e3_pin) |=> rate_r == LMCD_RATE_E3)
        else $error("e3 select did not force e3");

    a_sts1_ds3_pick: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && !host_pin && !e3_pin) |=>
        rate_r == ($past(sd_pin) ? LMCD_RATE_STS1 : LMCD_RATE_DS3))
        else $error("sts1 or ds3 decode wrong");

    a_rail_coder: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && !host_pin) |=> single_rail_o == $past(sr_pin)
        && coder_enable_o == single_rail_o)
        else $error("rail format or coder enable wrong");

    a_host_rail_bit: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && host_pin) |=> single_rail_o == $past(host_single_rail_i))
        else $error("host rail bit not applied");

    a_pullup_host: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && !control_mode_select_drv_i) |=> host_mode_r)
        else $error("floating mode pin did not give host mode");

endmodule

// *** hdl/lmcd_pkg.sv ***
// constants and types shared by the mode, clock and drive monitor block
package lmcd_pkg;

    // line rate selection
    typedef enum logic [1:0]
    {
        LMCD_RATE_DS3 = 2'b00,
        LMCD_RATE_STS1 = 2'b01,
        LMCD_RATE_E3 = 2'b10
    } lmcd_rate_t;

    // reference clock figures in kHz
    localparam int unsigned LMCD_SFM_REF_KHZ = 12288;
    localparam int unsigned LMCD_E3_KHZ = 34368;
    localparam int unsigned LMCD_DS3_KHZ = 44736;
    localparam int unsigned LMCD_STS1_KHZ = 51840;

    // synthesizer phase accumulator width and msb weight
    localparam int unsigned LMCD_ACC_W = 24;
    localparam logic [23:0] LMCD_ACC_ONE = 24'h800000;

    // driver monitor timeout, in transmit clock cycles
    localparam int unsigned LMCD_DMO_TIMEOUT = 128;
    localparam int unsigned LMCD_DMO_CNT_W = 8;
    localparam logic [7:0] LMCD_DMO_TERM = 8'(LMCD_DMO_TIMEOUT);

    // reset values
    localparam logic LMCD_RST_FAIL = 1'b0;
    localparam logic LMCD_RST_CLKOUT = 1'b0;

endpackage

// *** hdl/lmcd_clk_synth.sv ***
// rate clock synthesizer driven from the single frequency reference
`timescale 1ns/10ps
module lmcd_clk_synth
    import lmcd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire lmcd_pkg::lmcd_rate_t rate_i,
    output logic synth_clk_o
);
    import lmcd_pkg::*;

    logic [LMCD_ACC_W-1:0] acc_r;
    logic [LMCD_ACC_W-1:0] acc_nxt;
    logic [LMCD_ACC_W-1:0] inc;
    logic synth_clk_r;

    // increment so that acc msb toggles at line rate/(2 x sts1 rate) per tick;
    // mclk stands in for the synthesizer vco, so output is a rate model
    function automatic logic [LMCD_ACC_W-1:0] rate_inc(lmcd_rate_t r);
        logic [47:0] num;
        num = 48'd0;
        unique case (r)
            LMCD_RATE_E3: num = 48'(LMCD_E3_KHZ) * 48'(LMCD_ACC_ONE);
            LMCD_RATE_STS1: num = 48'(LMCD_STS1_KHZ) * 48'(LMCD_ACC_ONE);
            LMCD_RATE_DS3: num = 48'(LMCD_DS3_KHZ) * 48'(LMCD_ACC_ONE);
            default: num = 48'(LMCD_DS3_KHZ) * 48'(LMCD_ACC_ONE);
        endcase
        return LMCD_ACC_W'(num / 48'(LMCD_STS1_KHZ * 2));
    endfunction

    always_comb
    begin
        inc = rate_inc(rate_i);
        acc_nxt = acc_r + inc;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            acc_r <= '0;
        end
        else if (ce_i)
        begin
            if (run_i)
            begin
                acc_r <= acc_nxt;
            end
            else
            begin
                acc_r <= '0;
            end
        end
    end

    // output forced low outside single frequency operation
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            synth_clk_r <= LMCD_RST_CLKOUT;
        end
        else if (ce_i)
        begin
            synth_clk_r <= run_i & acc_r[LMCD_ACC_W-1];
        end
    end

    assign synth_clk_o = synth_clk_r;

endmodule

// *** sim/lmcd_line_model.sv ***
// line-side partner: transmit clock, monitor taps and negative rail
`timescale 1ns/10ps
module lmcd_line_model
(
    input wire logic mclk_i,
    input wire logic single_rail_i,
    input wire logic tip_req_i,
    input wire logic ring_req_i,
    output logic transmit_clock_o,
    output logic monitor_tip_o,
    output logic monitor_ring_o,
    output logic transmit_negative_data_o,
    output int tx_rise_cnt_o
);
    logic [2:0] div_r = 3'h0;
    logic tip_r = 1'b0;
    logic ring_r = 1'b0;
    int cnt_r = 0;

    // tx clock at mclk/8 keeps every tx phase several mclk samples wide
    always @(posedge mclk_i)
    begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'h3)
            cnt_r <= cnt_r + 1;
        // taps move on the falling tx edge so they are settled at the rise
        if (div_r == 3'h7)
        begin
            tip_r <= tip_req_i;
            ring_r <= ring_req_i;
        end
    end

    assign transmit_clock_o = div_r[2];
    assign monitor_tip_o = tip_r;
    assign monitor_ring_o = ring_r;
    assign tx_rise_cnt_o = cnt_r;
    assign transmit_negative_data_o = single_rail_i ? 1'b0 : div_r[0];
endmodule

// *** sim/lmcd_top_tb_top.sv ***
// self-checking bench for the mode, clock and drive monitor block
`timescale 1ns/10ps
module lmcd_top_tb_top;
    import lmcd_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic sfm, sfm_d, mode, mode_d, e3, e3_d, sts, sts_d, rail, rail_d;
    lmcd_rate_t host_rate = LMCD_RATE_DS3;
    logic host_sr = 1'b0;
    logic tip_req = 1'b0;
    logic ring_req = 1'b0;
    logic ce = 1'b1;
    logic mon_d = 1'b1;
    logic tnd;
    logic transmit_clock, tip, ring, host_mode, single_rail, coder, ref12, clkout, fail;
    lmcd_rate_t rate;
    logic [1:0] pins [3] = '{2'b10, 2'b00, 2'b01};
    int cnt, n, prev_n, t;
    int n_errors = 0;
    int n_checks = 0;

    always #5 mclk = ~mclk;

    lmcd_line_model u_line (.mclk_i(mclk), .single_rail_i(single_rail),
        .tip_req_i(tip_req), .ring_req_i(ring_req), .transmit_clock_o(transmit_clock),
        .monitor_tip_o(tip), .monitor_ring_o(ring),
        .transmit_negative_data_o(tnd), .tx_rise_cnt_o(cnt));

    lmcd_top u_dut (.mclk_i(mclk), .rstn_i(rstn), .ce_i(ce),
        .single_freq_enable_i(sfm), .single_freq_enable_drv_i(sfm_d),
        .control_mode_select_i(mode), .control_mode_select_drv_i(mode_d),
        .e3_select_i(e3), .e3_select_drv_i(e3_d),
        .sts1_ds3_select_i(sts), .sts1_ds3_select_drv_i(sts_d),
        .rail_format_select_i(rail), .rail_format_select_drv_i(rail_d),
        .host_rate_i(host_rate), .host_single_rail_i(host_sr),
        .transmit_clock_i(transmit_clock), .monitor_tip_input_i(tip),
        .monitor_tip_drv_i(mon_d), .monitor_ring_input_i(ring),
        .monitor_ring_drv_i(mon_d), .host_mode_o(host_mode), .rate_o(rate),
        .single_rail_o(single_rail), .coder_enable_o(coder),
        .ref_is_12m_o(ref12), .synthesized_clock_output_o(clkout),
        .driver_fail_flag_o(fail));

    task automatic chk(input logic [1:0] seen, input logic [1:0] exp,
        input string what);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s: %b not %b", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // undriven straps float to their pull level: mode up, the rest down
    task automatic strap(input logic [4:0] v, input logic [4:0] d);
        {sfm, mode, e3, sts, rail} = (v & d) | (5'b01000 & ~d);
        {sfm_d, mode_d, e3_d, sts_d, rail_d} = d;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic count_rises();
        logic p;
        n = 0;
        p = clkout;
        repeat (256)
        begin
            @(posedge mclk);
            #1;
            if (clkout && !p)
                n++;
            p = clkout;
        end
    endtask

    task automatic wait_rise();
        t = cnt;
        do
        begin
            @(posedge mclk);
            #1;
        end while (cnt == t);
    endtask

    // flag settles a few mclk after a tx rise, well before the next one
    task automatic edges(input int k);
        repeat (k) wait_rise();
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(input logic use_ring);
        wait_rise();
        tip_req = ~use_ring;
        ring_req = use_ring;
        wait_rise();
        tip_req = 1'b0;
        ring_req = 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        strap(5'h00, 5'h00);
        repeat (17) @(posedge mclk);
        #1;
        rstn = 1'b1;
        strap(5'h00, 5'h00);
        chk(host_mode, 1'b1, "host default");
        chk(rate, LMCD_RATE_DS3, "rate default");
        chk({single_rail, ref12}, 2'b00, "rail sfm default");
        chk(clkout, 1'b0, "clkout idle");
        host_rate = LMCD_RATE_STS1;
        host_sr = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            strap({2'b00, 3'(i)}, 5'h1f);
            chk(host_mode, 1'b0, "hw mode");
            chk(rate, i[2] ? LMCD_RATE_E3 :
                (i[1] ? LMCD_RATE_STS1 : LMCD_RATE_DS3), "hw rate");
            chk({single_rail, coder}, {2{i[0]}}, "hw rail");
            chk(tnd & i[0], 1'b0, "tnd grounded");
        end
        for (int i = 0; i < 3; i++)
        begin
            host_rate = lmcd_rate_t'(i);
            host_sr = i[0];
            strap({4'b0110, ~i[0]}, 5'h1f);
            chk(rate, 2'(i), "host rate");
            chk({single_rail, coder}, {2{i[0]}}, "host rail");
        end
        // enable low must hold every register through a strap change
        ce = 1'b0;
        strap(5'b00010, 5'h1f);
        chk(host_mode, 1'b1, "ce freeze mode");
        chk(rate, LMCD_RATE_E3, "ce freeze rate");
        ce = 1'b1;
        strap(5'b00010, 5'h1f);
        chk(rate, LMCD_RATE_STS1, "ce resume rate");
        prev_n = 0;
        for (int k = 0; k < 3; k++)
        begin
            strap({2'b10, pins[k], 1'b0}, 5'h1f);
            chk(ref12, 1'b1, "sfm ref");
            count_rises();
            chk(n > prev_n, 1'b1, "synth rate order");
            prev_n = n;
        end
        strap(5'h00, 5'h1f);
        count_rises();
        chk(ref12, 1'b0, "ref at line rate");
        chk({clkout, n == 0}, 2'b01, "synth off");
        pulse(1'b0);
        edges(127);
        chk(fail, 1'b0, "no fail at 127");
        edges(1);
        chk(fail, 1'b1, "fail at 128");
        edges(20);
        chk(fail, 1'b1, "fail held");
        // floating taps read low, so a pulse behind them is not seen
        mon_d = 1'b0;
        pulse(1'b0);
        edges(0);
        chk(fail, 1'b1, "floating taps");
        mon_d = 1'b1;
        pulse(1'b1);
        edges(0);
        chk(fail, 1'b0, "ring clears");
        edges(128);
        chk(fail, 1'b1, "fail after ring");
        pulse(1'b0);
        edges(0);
        chk(fail, 1'b0, "tip clears");
        print_verdict();
    end
endmodule
